// File: verilog/mwlpi_top.sv
`timescale 1ns/1ns
`include "mwlpi_cfg.svh"
// Function
// - Eight filter words share one address; each access advances an internal pointer.
// - Writing bit 31 of power register zeroes the pointer; bit self-clears next cycle.
// - Four filters: words 0-3 masks, 4 commands, 5 offsets, 6-7 CRCs.
// - Byte offset+j enters the CRC only when mask bit j (0..30) is set.
// - Command bit 0 enables filter; bit 3 selects multicast, clear selects unicast.
// - Eight-bit offset is the starting byte index; software keeps it at least 12.
// - CRC-16 poly 8005, init FFFF, no final XOR, compared with programmed value.
// - Global unicast bit makes any DA-passing unicast frame a wake-up frame.
// - Wake and magic received flags set on event; cleared by power register read.
// - Wake events need wake enable; magic events need magic enable.
// - Power-down drops frames; a wake or magic event clears it.
// - Auto mode enters idle when transmit drains; exits on frame/flush, clears enable.
// - Otherwise the idle enable bit directly enters and leaves transmit idle.
// - Software link bit; idle only after link up for the link timer period.
// - Live bits show receive idle (9) and transmit idle (8) states.
// - Receive idle entry and exit flags set on pattern changes; cleared on read.
// - Transmit entry flag on idle entry; exit flag after enable clear and wake timer.
// - Idle interrupt status on any idle entry or exit; cleared by idle register read.
// - Link timer counts milliseconds, default 1000; wake timer counts microseconds.
// - Wake interrupt status set on wake events, cleared once both received flags clear.
module mwlpi_top
	import mwlpi_pkg::*;
#(
	parameter int MS_CYCLES    = `MWLPI_MS_CYCLES,
	parameter int LINK_TIME_MS = `MWLPI_LINK_TIME_MS,
	parameter int WAKE_TIME_US = `MWLPI_WAKE_TIME_US
) (
	input  wire logic        clk,             // 10 MHz system clock
	input  wire logic        reset_n,         // Asynchronous reset
	input  wire logic [7:0]  regAddr,         // Register byte address
	input  wire logic [31:0] regWrData,       // Register write data
	input  wire logic        regWrEn,         // Write strobe
	input  wire logic        regRdEn,         // Read strobe
	output logic      [31:0] regRdData,       // Read data, cycle after strobe
	input  wire logic [47:0] stationAddr,     // Own MAC address, first byte in [7:0]
	input  wire logic        rxValid,         // Received byte valid
	input  wire logic [7:0]  rxByte,          // Received byte
	input  wire logic        rxSof,           // First byte of frame, with rxValid
	input  wire logic        rxEof,           // Frame end pulse, after last byte
	input  wire logic        rxDaPass,        // DA filter passed, valid at rxEof
	input  wire logic        txFramePending,  // Transmit frames outstanding
	input  wire logic        txFifoFlush,     // Transmit FIFO flush request pulse
	input  wire logic        rxIdlePattern,   // Idle pattern seen on PHY receive
	output logic             rxDropFrame,     // Power-down: drop received frames
	output logic             txIdleActive,    // Send idle pattern to PHY
	output logic             rxIdleState,     // Receiver in idle state
	output logic             wakeIrqStatus,   // Power management event status
	output logic             idleIrqStatus    // Idle entry/exit status
);

	// Everything starts at zero apart from the one-hot state codes
	localparam mwlpi_state_t STATE_RESET = '{txState: TX_NORMAL, mgState: MG_SYNC, default: '0};

	mwlpi_state_t s_q;
	mwlpi_state_t s_d;

	function automatic logic [15:0] crc16Byte(input logic [15:0] crcIn, input logic [7:0] b);
		logic [15:0] c;
		logic        fb;
		c = crcIn;
		for (int k = 0; k < 8; k++) begin
			fb = c[15] ^ b[k];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ `MWLPI_CRC_POLY;
			end
		end
		return c;
	endfunction

	function automatic logic [7:0] addrByte(input logic [47:0] addr, input logic [2:0] pos);
		logic [47:0] sh;
		sh = addr >> {pos, 3'b000};
		return sh[7:0];
	endfunction

	// Read views of the mixed registers; the clear-on-read side effects stay with the strobe
	function automatic logic [31:0] pmtView(input mwlpi_state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`MWLPI_PMT_PTR_RST] = s.ptrRst;
		v[`MWLPI_PMT_GU] = s.gu;
		v[`MWLPI_PMT_WPR] = s.wake_frame_received;
		v[`MWLPI_PMT_MPR] = s.magic_frame_received;
		v[`MWLPI_PMT_WFE] = s.wake_frame_enable;
		v[`MWLPI_PMT_MPE] = s.magic_frame_enable;
		v[`MWLPI_PMT_PD] = s.pd;
		return v;
	endfunction

	function automatic logic [31:0] idleView(input mwlpi_state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`MWLPI_LPI_TXA] = s.txa;
		v[`MWLPI_LPI_LINK_STATE_ENABLE] = s.link_state_enable;
		v[`MWLPI_LPI_PLS] = s.phy_link_up_flag;
		v[`MWLPI_LPI_EN] = s.idle_enable;
		v[`MWLPI_LPI_RX_ST] = s.rxIdle;
		v[`MWLPI_LPI_TX_ST] = s.txLpi;
		v[`MWLPI_LPI_RX_EXIT] = s.rxExit;
		v[`MWLPI_LPI_RX_ENTRY] = s.rxEntry;
		v[`MWLPI_LPI_TX_EXIT] = s.txExit;
		v[`MWLPI_LPI_TX_ENTRY] = s.txEntry;
		return v;
	endfunction

	// One filter's verdict at frame end: enabled, right address type and equal CRC
	function automatic logic filterMatch(input logic [7:0][31:0] wf, input logic [15:0] crc, input logic mcast,
		input int i);
		logic [3:0]  cmd;
		logic [15:0] want;
		cmd = wf[`MWLPI_WF_CMD_WORD][i*8 +: 4];
		want = wf[`MWLPI_WF_CRC_WORD + i/2][(i%2)*16 +: 16];
		return cmd[0] && (cmd[3] == mcast) && ((crc ^ `MWLPI_CRC_XOROUT) == want);
	endfunction

	always_comb begin
		logic [31:0] rd;
		logic [8:0]  idx;
		logic [8:0]  rel;
		logic [8:0]  ofs;
		logic [15:0] base;
		logic [2:0]  ffc;
		logic        anyMatch;
		logic        wakeHit;
		logic        magicHit;
		logic        linkOk;
		logic        usTick;
		logic        msTick;
		logic        leave;
		mwlpi_magic_t mst;
		rd = 32'h0000_0000;
		idx = 9'h000;
		rel = 9'h000;
		ofs = 9'h000;
		base = 16'h0000;
		ffc = 3'h0;
		anyMatch = 1'b0;
		wakeHit = 1'b0;
		magicHit = 1'b0;
		leave = 1'b0;
		mst = MG_SYNC;
		linkOk = 1'b0;
		usTick = 1'b0;
		msTick = 1'b0;
		s_d = s_q;
		// Read data stands for one cycle only; the bus sees zero otherwise
		s_d.rdData = 32'h0000_0000;

		// Register writes
		if (regWrEn) begin
			if (regAddr == `MWLPI_OFS_WAKE_FILTER) begin
				s_d.wf[s_q.ptr] = regWrData;
				s_d.ptr = s_q.ptr + 3'h1;
			end else if (regAddr == `MWLPI_OFS_PMT) begin
				s_d.ptrRst = regWrData[`MWLPI_PMT_PTR_RST];
				s_d.gu = regWrData[`MWLPI_PMT_GU];
				s_d.wake_frame_enable = regWrData[`MWLPI_PMT_WFE];
				s_d.magic_frame_enable = regWrData[`MWLPI_PMT_MPE];
				s_d.pd = regWrData[`MWLPI_PMT_PD];
			end else if (regAddr == `MWLPI_OFS_IDLE) begin
				s_d.txa = regWrData[`MWLPI_LPI_TXA];
				s_d.link_state_enable = regWrData[`MWLPI_LPI_LINK_STATE_ENABLE];
				s_d.phy_link_up_flag = regWrData[`MWLPI_LPI_PLS];
				s_d.idle_enable = regWrData[`MWLPI_LPI_EN];
			end
		end

		// Register reads; flags clear here and any set below still wins
		if (regRdEn) begin
			if (regAddr == `MWLPI_OFS_WAKE_FILTER) begin
				rd = s_q.wf[s_q.ptr];
				s_d.ptr = s_q.ptr + 3'h1;
			end else if (regAddr == `MWLPI_OFS_PMT) begin
				rd = pmtView(s_q);
				s_d.wake_frame_received = 1'b0;
				s_d.magic_frame_received = 1'b0;
			end else if (regAddr == `MWLPI_OFS_IDLE) begin
				rd = idleView(s_q);
				s_d.rxExit = 1'b0;
				s_d.rxEntry = 1'b0;
				s_d.txExit = 1'b0;
				s_d.txEntry = 1'b0;
				s_d.idle_interrupt_status = 1'b0;
			end
			s_d.rdData = rd;
		end

		// Pointer reset acts one cycle after the write, then the bit drops
		if (s_q.ptrRst) begin
			s_d.ptr = 3'h0;
			s_d.ptrRst = 1'b0;
		end

		// Receive byte stream: filter CRCs and magic frame search
		if (rxValid) begin
			idx = rxSof ? 9'h000 : s_q.byteIdx;
			if (rxSof) begin
				s_d.mcast = rxByte[0];
			end
			for (int i = 0; i < 4; i++) begin
				ofs = {1'b0, s_q.wf[`MWLPI_WF_OFS_WORD][i*8 +: 8]};
				rel = idx - ofs;
				base = rxSof ? `MWLPI_CRC_INIT : s_q.crc[i];
				if (idx >= ofs && rel < 9'(`MWLPI_WF_MASK_BITS) && s_q.wf[i][rel[4:0]]) begin
					s_d.crc[i] = crc16Byte(base, rxByte);
				end else begin
					s_d.crc[i] = base;
				end
			end
			// Index saturates so a very long frame cannot wrap back into a filter window
			s_d.byteIdx = (idx == 9'h1FF) ? idx : idx + 9'h001;

			mst = rxSof ? MG_SYNC : s_q.mgState;
			ffc = rxSof ? 3'h0 : s_q.ffCnt;
			case (mst)
				MG_SYNC: begin
					if (rxByte == 8'hFF) begin
						s_d.ffCnt = (ffc == `MWLPI_MAGIC_SYNC) ? ffc : ffc + 3'h1;
						s_d.mgState = MG_SYNC;
					end else if (ffc == `MWLPI_MAGIC_SYNC && rxByte == addrByte(stationAddr, 3'h0)) begin
						s_d.mgState = MG_ADDR;
						s_d.mgPos = 3'h1;
						s_d.mgRep = 4'h0;
						s_d.ffCnt = 3'h0;
					end else begin
						s_d.mgState = MG_SYNC;
						s_d.ffCnt = 3'h0;
					end
				end
				MG_ADDR: begin
					if (rxByte == addrByte(stationAddr, s_q.mgPos)) begin
						if (s_q.mgPos == 3'h5) begin
							s_d.mgPos = 3'h0;
							if (s_q.mgRep == `MWLPI_MAGIC_REPS) begin
								s_d.mgState = MG_DONE;
							end else begin
								s_d.mgRep = s_q.mgRep + 4'h1;
							end
						end else begin
							s_d.mgPos = s_q.mgPos + 3'h1;
						end
					end else begin
						s_d.mgState = MG_SYNC;
						s_d.ffCnt = (rxByte == 8'hFF) ? 3'h1 : 3'h0;
					end
				end
				// A completed match holds until the next frame start
				MG_DONE: begin
					s_d.mgState = MG_DONE;
				end
				default: begin
					s_d.mgState = MG_SYNC;
				end
			endcase
		end

		// Frame end: decide wake events
		if (rxEof) begin
			for (int i = 0; i < 4; i++) begin
				if (filterMatch(s_q.wf, s_q.crc[i], s_q.mcast, i)) begin
					anyMatch = 1'b1;
				end
			end
			wakeHit = s_q.pd && s_q.wake_frame_enable && (anyMatch || (s_q.gu && !s_q.mcast && rxDaPass));
			magicHit = s_q.pd && s_q.magic_frame_enable && (s_q.mgState == MG_DONE);
			if (wakeHit) begin
				s_d.wake_frame_received = 1'b1;
			end
			if (magicHit) begin
				s_d.magic_frame_received = 1'b1;
			end
			if (wakeHit || magicHit) begin
				s_d.pd = 1'b0;
			end
		end
		// Status follows the two received flags, so it drops exactly when a read clears both
		s_d.wakeIs = s_d.wake_frame_received | s_d.magic_frame_received;

		// Microsecond and millisecond ticks
		usTick = (s_q.usPre == 4'(`MWLPI_US_CYCLES - 1));
		s_d.usPre = usTick ? 4'h0 : s_q.usPre + 4'h1;
		msTick = (s_q.msPre == 16'(MS_CYCLES - 1));
		s_d.msPre = msTick ? 16'h0000 : s_q.msPre + 16'h0001;

		// Link must stay up for the full link time before idle is allowed
		if (!s_q.phy_link_up_flag) begin
			s_d.linkCnt = 16'h0000;
			// Held while the link is down so the first counted millisecond is whole
			s_d.msPre = 16'h0000;
		end else if (msTick && s_q.linkCnt < 16'(LINK_TIME_MS)) begin
			s_d.linkCnt = s_q.linkCnt + 16'h0001;
		end
		linkOk = (s_q.linkCnt >= 16'(LINK_TIME_MS));

		// Transmit idle control
		case (s_q.txState)
			TX_NORMAL: begin
				if (s_q.idle_enable && linkOk && !(s_q.txa && (txFramePending || txFifoFlush))) begin
					s_d.txState = TX_IDLE;
					s_d.txEntry = 1'b1;
					s_d.idle_interrupt_status = 1'b1;
				end
			end
			TX_IDLE: begin
				leave = s_q.txa ? (txFramePending || txFifoFlush) : !s_q.idle_enable;
				if (leave) begin
					s_d.txState = TX_WAKE;
					s_d.wakeCnt = 16'h0000;
					// Fresh divider start: a partial first tick would cut the wake time short
					s_d.usPre = 4'h0;
					if (s_q.txa) begin
						s_d.idle_enable = 1'b0;
					end
				end
			end
			TX_WAKE: begin
				if (usTick) begin
					if (s_q.wakeCnt + 16'h0001 >= 16'(WAKE_TIME_US)) begin
						s_d.txState = TX_NORMAL;
						s_d.txExit = 1'b1;
						s_d.idle_interrupt_status = 1'b1;
					end else begin
						s_d.wakeCnt = s_q.wakeCnt + 16'h0001;
					end
				end
			end
			default: begin
				s_d.txState = TX_NORMAL;
			end
		endcase
		// Registered copy of the idle state keeps the output free of decode glitches
		s_d.txLpi = (s_d.txState == TX_IDLE);

		// Receive idle detection; a change counts once stages two and three agree
		s_d.rxSync = {s_q.rxSync[1:0], rxIdlePattern};
		if (s_q.rxSync[1] == s_q.rxSync[2] && s_q.rxSync[2] != s_q.rxIdle) begin
			s_d.rxIdle = s_q.rxSync[2];
			if (s_q.rxSync[2]) begin
				s_d.rxEntry = 1'b1;
			end else begin
				s_d.rxExit = 1'b1;
			end
			s_d.idle_interrupt_status = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign rxDropFrame = s_q.pd;
	assign txIdleActive = s_q.txLpi;
	assign rxIdleState = s_q.rxIdle;
	assign wakeIrqStatus = s_q.wakeIs;
	assign idleIrqStatus = s_q.idle_interrupt_status;

endmodule

// File: common/mwlpi_cfg.svh
`ifndef MWLPI_CFG_SVH
`define MWLPI_CFG_SVH

// Register offsets (byte addresses)
`define MWLPI_OFS_WAKE_FILTER  8'h28
`define MWLPI_OFS_PMT          8'h2C
`define MWLPI_OFS_IDLE         8'h30

// power_mgmt_control_status fields
`define MWLPI_PMT_PTR_RST      31
`define MWLPI_PMT_GU           9
`define MWLPI_PMT_WPR          6
`define MWLPI_PMT_MPR          5
`define MWLPI_PMT_WFE          2
`define MWLPI_PMT_MPE          1
`define MWLPI_PMT_PD           0

// low_power_idle_control_status fields
`define MWLPI_LPI_TXA          19
`define MWLPI_LPI_LINK_STATE_ENABLE        18
`define MWLPI_LPI_PLS          17
`define MWLPI_LPI_EN           16
`define MWLPI_LPI_RX_ST        9
`define MWLPI_LPI_TX_ST        8
`define MWLPI_LPI_RX_EXIT      3
`define MWLPI_LPI_RX_ENTRY     2
`define MWLPI_LPI_TX_EXIT      1
`define MWLPI_LPI_TX_ENTRY     0

// Wake filter word layout
`define MWLPI_WF_CMD_WORD      4
`define MWLPI_WF_OFS_WORD      5
`define MWLPI_WF_CRC_WORD      6
`define MWLPI_WF_MASK_BITS     31

// CRC-16
`define MWLPI_CRC_POLY         16'h8005
`define MWLPI_CRC_INIT         16'hFFFF
`define MWLPI_CRC_XOROUT       16'h0000

// Magic frame
`define MWLPI_MAGIC_SYNC       3'h6
`define MWLPI_MAGIC_REPS       4'hF

// Timing
`define MWLPI_CLK_KHZ          10000
`define MWLPI_US_CYCLES        (`MWLPI_CLK_KHZ / 1000)
`define MWLPI_MS_CYCLES        (`MWLPI_CLK_KHZ)
`define MWLPI_LINK_TIME_MS     1000
`define MWLPI_WAKE_TIME_US     30

`endif

// File: common/mwlpi_pkg.sv
package mwlpi_pkg;

	typedef enum logic [2:0] {
		TX_NORMAL = 3'b001,
		TX_IDLE   = 3'b010,
		TX_WAKE   = 3'b100
	} mwlpi_tx_t;

	typedef enum logic [2:0] {
		MG_SYNC = 3'b001,
		MG_ADDR = 3'b010,
		MG_DONE = 3'b100
	} mwlpi_magic_t;

	typedef struct packed {
		logic [7:0][31:0] wf;
		logic [2:0]       ptr;
		logic             ptrRst;
		logic             gu;
		logic             wake_frame_enable;
		logic             magic_frame_enable;
		logic             pd;
		logic             wake_frame_received;
		logic             magic_frame_received;
		logic             wakeIs;
		logic             txa;
		logic             link_state_enable;
		logic             phy_link_up_flag;
		logic             idle_enable;
		logic             rxIdle;
		logic             rxExit;
		logic             rxEntry;
		logic             txExit;
		logic             txEntry;
		logic             idle_interrupt_status;
		logic             txLpi;
		logic [2:0]       rxSync;
		mwlpi_tx_t        txState;
		mwlpi_magic_t     mgState;
		logic [2:0]       ffCnt;
		logic [2:0]       mgPos;
		logic [3:0]       mgRep;
		logic             mcast;
		logic [8:0]       byteIdx;
		logic [3:0][15:0] crc;
		logic [3:0]       usPre;
		logic [15:0]      msPre;
		logic [15:0]      linkCnt;
		logic [15:0]      wakeCnt;
		logic [31:0]      rdData;
	} mwlpi_state_t;

endpackage

// File: dv/mwlpi_top_props.sv
`timescale 1ns/1ns
module mwlpi_top_props (
	input wire logic        clk,            // Clock
	input wire logic        reset_n,        // Reset
	input wire logic [7:0]  regAddr,        // Address
	input wire logic        regWrEn,        // Write
	input wire logic        regRdEn,        // Read
	input wire logic [31:0] regRdData,      // Read data
	input wire logic        rxEof,          // Frame end
	input wire logic        txFramePending, // Pending
	input wire logic        txFifoFlush,    // Flush
	input wire logic        rxIdlePattern,  // Idle seen
	input wire logic        rxDropFrame,    // Drop
	input wire logic        txIdleActive,   // Tx idle
	input wire logic        rxIdleState,    // Rx idle
	input wire logic        wakeIrqStatus,  // Wake status
	input wire logic        idleIrqStatus   // Idle status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_dropEnd;
		rxEof && rxDropFrame;
	endsequence
	sequence s_pmtRead;
		regRdEn && regAddr == 8'h2C && !rxEof;
	endsequence

	property p_rdZero;
		!$past(regRdEn) |-> regRdData == 32'h0;
	endproperty
	a_rdZero: assert property (p_rdZero) else $error("read data outside read slot");
	property p_pmtClr;
		s_pmtRead |=> !wakeIrqStatus;
	endproperty
	a_pmtClr: assert property (p_pmtClr) else $error("wake status kept after read");
	property p_wakeSrc;
		$rose(wakeIrqStatus) |-> $past(rxEof) && $past(rxDropFrame);
	endproperty
	a_wakeSrc: assert property (p_wakeSrc) else $error("wake status without frame");
	property p_pdEnd;
		s_dropEnd ##1 $rose(wakeIrqStatus) |-> !rxDropFrame;
	endproperty
	a_pdEnd: assert property (p_pdEnd) else $error("power down kept after wake");
	property p_txHold;
		txIdleActive && !regWrEn && !$past(regWrEn) && !txFramePending && !txFifoFlush |=> txIdleActive;
	endproperty
	a_txHold: assert property (p_txHold) else $error("tx idle left without cause");
	property p_txIrq;
		$rose(txIdleActive) |-> idleIrqStatus;
	endproperty
	a_txIrq: assert property (p_txIrq) else $error("no idle status on entry");
	property p_rxUp;
		rxIdlePattern [*6] |-> rxIdleState;
	endproperty
	a_rxUp: assert property (p_rxUp) else $error("rx idle state missing");
	property p_rxDn;
		!rxIdlePattern [*6] |-> !rxIdleState;
	endproperty
	a_rxDn: assert property (p_rxDn) else $error("rx idle state stuck");
endmodule

bind mwlpi_top mwlpi_top_props i_props (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
	.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .rxEof(rxEof),
	.txFramePending(txFramePending), .txFifoFlush(txFifoFlush), .rxIdlePattern(rxIdlePattern),
	.rxDropFrame(rxDropFrame), .txIdleActive(txIdleActive), .rxIdleState(rxIdleState),
	.wakeIrqStatus(wakeIrqStatus), .idleIrqStatus(idleIrqStatus));

// File: dv/mwlpi_phy_model.sv
`timescale 1ns/1ns
module mwlpi_phy_model (
	input  wire logic clk,           // Clock
	output logic       rxValid,       // Byte valid
	output logic [7:0] rxByte,        // Byte
	output logic       rxSof,         // First byte
	output logic       rxEof,         // Frame end
	output logic       rxDaPass,      // DA passed
	output logic       rxIdlePattern  // Idle pattern
);
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		rxSof = 1'b0;
		rxEof = 1'b0;
		rxDaPass = 1'b0;
		rxIdlePattern = 1'b0;
	end

	// Bytes back to back, end pulse one cycle after the last byte
	task automatic send(input logic [7:0] f[$], input logic da);
		@(posedge clk);
		for (int i = 0; i < f.size(); i++) begin
			rxValid <= 1'b1;
			rxSof <= (i == 0);
			rxByte <= f[i];
			@(posedge clk);
		end
		rxValid <= 1'b0;
		rxSof <= 1'b0;
		rxByte <= ~f[f.size() - 1];
		rxEof <= 1'b1;
		rxDaPass <= da;
		@(posedge clk);
		rxEof <= 1'b0;
		rxDaPass <= ~da;
	endtask

	task automatic idle(input logic on);
		@(posedge clk);
		rxIdlePattern <= on;
	endtask
endmodule

// File: dv/tb_mwlpi_top.sv
`timescale 1ns/1ns
module tb_mwlpi_top;
	localparam logic [47:0] SA = 48'h665544332211;
	logic        clk, reset_n, regWrEn, regRdEn, txFramePending, txFifoFlush;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData;
	logic        rxValid, rxSof, rxEof, rxDaPass, rxIdlePattern;
	logic [7:0]  rxByte;
	logic [47:0] stationAddr;
	logic        rxDropFrame, txIdleActive, rxIdleState, wakeIrqStatus, idleIrqStatus;
	logic [7:0]  fr[$], fb[$], mg[$];
	logic [31:0] w[8];
	int          error_cnt, compares;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	mwlpi_top #(.MS_CYCLES(20), .LINK_TIME_MS(2)) i_mwlpi_top (
		.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData), .stationAddr(stationAddr), .rxValid(rxValid), .rxByte(rxByte),
		.rxSof(rxSof), .rxEof(rxEof), .rxDaPass(rxDaPass), .txFramePending(txFramePending),
		.txFifoFlush(txFifoFlush), .rxIdlePattern(rxIdlePattern), .rxDropFrame(rxDropFrame),
		.txIdleActive(txIdleActive), .rxIdleState(rxIdleState), .wakeIrqStatus(wakeIrqStatus),
		.idleIrqStatus(idleIrqStatus));
	mwlpi_phy_model i_phy (.clk(clk), .rxValid(rxValid), .rxByte(rxByte), .rxSof(rxSof), .rxEof(rxEof),
		.rxDaPass(rxDaPass), .rxIdlePattern(rxIdlePattern));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 chk(regRdData, exp);
	endtask
	task automatic waitTx(input logic v);
		int n;
		n = 0;
		while (txIdleActive !== v && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(txIdleActive, v);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_sim;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Shift order mirrors the receiver: each byte enters LSB first
	function automatic logic [15:0] crc16(input logic [7:0] f[$], input int ofs, input logic [30:0] m);
		logic [15:0] c;
		logic        b0;
		c = 16'hFFFF;
		for (int j = 0; j < 31; j++)
			if (m[j])
				for (int b = 0; b < 8; b++) begin
					b0 = c[15] ^ f[ofs + j][b];
					c = {c[14:0], 1'b0} ^ (b0 ? 16'h8005 : 16'h0000);
				end
		return c;
	endfunction

	initial begin
		repeat (10000) @(posedge clk);
		error_cnt++;
		end_sim();
	end

	initial begin
		{reset_n, regWrEn, regRdEn, txFramePending, txFifoFlush} = 5'h00;
		regAddr = 8'h00;
		regWrData = 32'h0;
		stationAddr = SA;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h2C, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h00, 32'h0);
		chk(rxDropFrame, 1'b0);
		done("reset");
		for (int i = 0; i < 20; i++) fr.push_back(8'h10 + i);
		fb = fr;
		fb[13] = 8'hAA;
		w = '{32'h0000000F, 32'h0, 32'h0, 32'h0, 32'h1, 32'hC, {16'h0, crc16(fr, 12, 31'hF)}, 32'h0};
		wr(8'h2C, 32'h80000000);
		foreach (w[i]) wr(8'h28, w[i]);
		rd(8'h28, w[0]);
		wr(8'h2C, 32'h80000000);
		rd(8'h2C, 32'h0);
		for (int i = 0; i < 9; i++) rd(8'h28, w[i % 8]);
		done("filter");
		wr(8'h2C, 32'h5);
		@(negedge clk);
		chk(rxDropFrame, 1'b1);
		i_phy.send(fr, 1'b1);
		repeat (2) @(negedge clk);
		chk(wakeIrqStatus, 1'b1);
		chk(rxDropFrame, 1'b0);
		rd(8'h2C, 32'h44);
		chk(wakeIrqStatus, 1'b0);
		wr(8'h2C, 32'h205);
		i_phy.send(fb, 1'b1);
		repeat (2) @(negedge clk);
		rd(8'h2C, 32'h244);
		wr(8'h2C, 32'h3);
		i_phy.send(fr, 1'b1);
		repeat (2) @(negedge clk);
		chk(rxDropFrame, 1'b1);
		for (int i = 0; i < 12; i++) mg.push_back(8'h02);
		for (int i = 0; i < 6; i++) mg.push_back(8'hFF);
		for (int i = 0; i < 96; i++) mg.push_back(SA[8 * (i % 6) +: 8]);
		@(posedge clk);
		stationAddr <= SA ^ 48'h0000_0000_0001;
		i_phy.send(mg, 1'b1);
		repeat (2) @(negedge clk);
		chk(rxDropFrame, 1'b1);
		@(posedge clk);
		stationAddr <= SA;
		i_phy.send(mg, 1'b1);
		repeat (2) @(negedge clk);
		chk(rxDropFrame, 1'b0);
		rd(8'h2C, 32'h22);
		rd(8'h2C, 32'h2);
		done("wake");
		wr(8'h30, 32'h30000);
		repeat (38) @(negedge clk);
		chk(txIdleActive, 1'b0);
		waitTx(1'b1);
		chk(idleIrqStatus, 1'b1);
		rd(8'h30, 32'h30101);
		chk(idleIrqStatus, 1'b0);
		wr(8'h30, 32'h20000);
		waitTx(1'b0);
		repeat (100) @(negedge clk);
		rd(8'h30, 32'h20000);
		repeat (250) @(negedge clk);
		rd(8'h30, 32'h20002);
		@(posedge clk);
		txFramePending <= 1'b1;
		wr(8'h30, 32'hB0000);
		repeat (60) @(negedge clk);
		chk(txIdleActive, 1'b0);
		@(posedge clk);
		txFramePending <= 1'b0;
		waitTx(1'b1);
		@(posedge clk);
		txFifoFlush <= 1'b1;
		@(posedge clk);
		txFifoFlush <= 1'b0;
		waitTx(1'b0);
		repeat (350) @(negedge clk);
		rd(8'h30, 32'hA0003);
		done("tx idle");
		i_phy.idle(1'b1);
		repeat (8) @(negedge clk);
		chk(rxIdleState, 1'b1);
		rd(8'h30, 32'hA0204);
		i_phy.idle(1'b0);
		repeat (8) @(negedge clk);
		chk(rxIdleState, 1'b0);
		rd(8'h30, 32'hA0008);
		i_phy.idle(1'b1);
		repeat (8) @(negedge clk);
		i_phy.idle(1'b0);
		repeat (8) @(negedge clk);
		chk(idleIrqStatus, 1'b1);
		chk(rxIdleState, 1'b0);
		rd(8'h30, 32'hA000C);
		done("rx idle");
		end_sim();
	end
endmodule
